// ### design/bsa_config_regs.sv
// Purpose: Clock recovery and gain control configuration registers with field decode
// Assumes: Register port and status inputs synchronous to ref_clk
// Notes:   Read data appears one cycle after the read strobe
`timescale 1ns/1ns
`default_nettype none
`include "bsa_defs.svh"

module bsa_config_regs (
    input  wire logic                    ref_clk,
    input  wire logic                    reset_n,
    input  wire logic [`BSA_ADDR_W-1:0]  reg_addr,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    input  wire logic [`BSA_DATA_W-1:0]  reg_wdata,
    output logic      [`BSA_DATA_W-1:0]  reg_rdata,
    input  wire logic                    sync_detected,
    input  wire logic                    carrier_sense,
    input  wire logic                    loop_gate_on_carrier,
    output logic      [3:0]              integral_gain_halves,
    output logic      [2:0]              proportional_gain_mult,
    output logic      [2:0]              rate_offset_limit,
    output logic      [1:0]              digital_amp_barred_steps,
    output logic      [2:0]              front_amp_cap_code,
    output logic      [5:0]              filter_target_db,
    output logic                         loops_frozen
);

    // ****************************************
    // Functions
    // ****************************************
    function automatic logic addr_hit(
        input logic [`BSA_ADDR_W-1:0] addr,
        input logic [`BSA_ADDR_W-1:0] target
    );
        addr_hit = (addr == target);
    endfunction

    function automatic logic [7:0] read_mux(
        input logic [`BSA_ADDR_W-1:0] addr,
        input logic [7:0]             bs,
        input logic [7:0]             gl
    );
        if (addr_hit(addr, `BSA_BIT_SYNC_ADDR)) begin
            read_mux = bs;
        end else if (addr_hit(addr, `BSA_GAIN_LIMITS_ADDR)) begin
            read_mux = gl;
        end else begin
            read_mux = 8'h00;
        end
    endfunction

    function automatic logic [2:0] gain_mult(input logic [1:0] sel);
        gain_mult = {1'b0, sel} + 3'h1;
    endfunction

    function automatic logic [3:0] integral_halves(
        input logic       sync,
        input logic       post_half,
        input logic [1:0] sel
    );
        if (sync && post_half) begin
            integral_halves = 4'h1;
        end else begin
            integral_halves = {gain_mult(sel), 1'b0};
        end
    endfunction

    function automatic logic [2:0] proportional_mult(
        input logic       sync,
        input logic       post_base,
        input logic [1:0] sel
    );
        if (sync && post_base) begin
            proportional_mult = 3'h1;
        end else begin
            proportional_mult = gain_mult(sel);
        end
    endfunction

    function automatic logic [2:0] rate_limit(input logic [1:0] code);
        case (code)
            2'h0:    rate_limit = 3'h0;
            2'h1:    rate_limit = 3'h1;
            2'h2:    rate_limit = 3'h2;
            default: rate_limit = 3'h4;
        endcase
    endfunction

    function automatic logic [5:0] target_db(input logic [2:0] code);
        case (code)
            3'h0:    target_db = 6'h18;
            3'h1:    target_db = 6'h1b;
            3'h2:    target_db = 6'h1e;
            3'h3:    target_db = 6'h21;
            3'h4:    target_db = 6'h24;
            3'h5:    target_db = 6'h26;
            3'h6:    target_db = 6'h28;
            default: target_db = 6'h2a;
        endcase
    endfunction

    // ****************************************
    // State
    // ****************************************
    bsa_pkg::bsa_state_s state;
    bsa_pkg::bsa_state_s next_state;

    logic [7:0] bs_cfg;
    logic [7:0] gl_cfg;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        next_state = state;
        bs_cfg     = state.bit_sync_loop_config;
        gl_cfg     = state.gain_control_limits;

        // Register writes
        if (reg_wr && addr_hit(reg_addr, `BSA_BIT_SYNC_ADDR)) begin
            next_state.bit_sync_loop_config = reg_wdata;
        end
        if (reg_wr && addr_hit(reg_addr, `BSA_GAIN_LIMITS_ADDR)) begin
            next_state.gain_control_limits = reg_wdata;
        end

        // Reads return the value held before this edge
        if (reg_rd) begin
            next_state.rdata = read_mux(reg_addr, bs_cfg, gl_cfg);
        end

        // Integral gain in units of half the base gain
        next_state.integral_gain_halves = integral_halves(
            sync_detected,
            bs_cfg[`BSA_POST_KI_BIT],
            bs_cfg[`BSA_PRE_KI_HI:`BSA_PRE_KI_LO]
        );
        next_state.proportional_gain_mult = proportional_mult(
            sync_detected,
            bs_cfg[`BSA_POST_KP_BIT],
            bs_cfg[`BSA_PRE_KP_HI:`BSA_PRE_KP_LO]
        );

        // Limit in units of 1/32 of the data rate
        next_state.rate_offset_limit = rate_limit(
            bs_cfg[`BSA_RATE_SAT_HI:`BSA_RATE_SAT_LO]
        );

        // Gain control limits
        next_state.digital_amp_barred_steps = gl_cfg[`BSA_DIGITAL_VARIABLE_AMP_CAP_HI:`BSA_DIGITAL_VARIABLE_AMP_CAP_LO];
        next_state.front_amp_cap_code = gl_cfg[`BSA_LNA_CAP_HI:`BSA_LNA_CAP_LO];
        next_state.filter_target_db = target_db(
            gl_cfg[`BSA_TARGET_HI:`BSA_TARGET_LO]
        );

        // Loop gating
        next_state.loops_frozen = loop_gate_on_carrier && !carrier_sense;
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state.bit_sync_loop_config     <= `BSA_BIT_SYNC_RESET;
            state.gain_control_limits      <= `BSA_GAIN_LIMITS_RESET;
            state.rdata                    <= 8'h00;
            state.integral_gain_halves     <= 4'h4;
            state.proportional_gain_mult   <= 3'h3;
            state.rate_offset_limit        <= 3'h0;
            state.digital_amp_barred_steps <= 2'h0;
            state.front_amp_cap_code       <= 3'h0;
            state.filter_target_db         <= 6'h21;
            state.loops_frozen             <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign reg_rdata                = state.rdata;
    assign integral_gain_halves     = state.integral_gain_halves;
    assign proportional_gain_mult   = state.proportional_gain_mult;
    assign rate_offset_limit        = state.rate_offset_limit;
    assign digital_amp_barred_steps = state.digital_amp_barred_steps;
    assign front_amp_cap_code       = state.front_amp_cap_code;
    assign filter_target_db         = state.filter_target_db;
    assign loops_frozen             = state.loops_frozen;

endmodule

`default_nettype wire

// ### design/bsa_defs.svh
// Purpose: Offsets, field positions, reset values for the loop and gain configuration
// Assumes: Registers sit at their printed addresses on the register port
// Notes:   Macros only
`ifndef BSA_DEFS_SVH
`define BSA_DEFS_SVH

`define BSA_ADDR_W            6
`define BSA_DATA_W            8
`define BSA_BIT_SYNC_ADDR     6'h1a
`define BSA_GAIN_LIMITS_ADDR  6'h1b

`define BSA_PRE_KI_HI         7
`define BSA_PRE_KI_LO         6
`define BSA_PRE_KP_HI         5
`define BSA_PRE_KP_LO         4
`define BSA_POST_KI_BIT       3
`define BSA_POST_KP_BIT       2
`define BSA_RATE_SAT_HI       1
`define BSA_RATE_SAT_LO       0
`define BSA_BIT_SYNC_RESET    8'h6c

`define BSA_DIGITAL_VARIABLE_AMP_CAP_HI       7
`define BSA_DIGITAL_VARIABLE_AMP_CAP_LO       6
`define BSA_LNA_CAP_HI        5
`define BSA_LNA_CAP_LO        3
`define BSA_TARGET_HI         2
`define BSA_TARGET_LO         0
`define BSA_GAIN_LIMITS_RESET 8'h03

`endif

// ### design/bsa_pkg.sv
// Purpose: Types for the loop and gain configuration block
// Assumes: Nothing beyond the defs header
// Notes:   One packed struct holds all state
package bsa_pkg;

    typedef struct packed {
        logic [7:0] bit_sync_loop_config;
        logic [7:0] gain_control_limits;
        logic [7:0] rdata;
        logic [3:0] integral_gain_halves;
        logic [2:0] proportional_gain_mult;
        logic [2:0] rate_offset_limit;
        logic [1:0] digital_amp_barred_steps;
        logic [2:0] front_amp_cap_code;
        logic [5:0] filter_target_db;
        logic       loops_frozen;
    } bsa_state_s;

endpackage

// ### verif/bsa_checker_properties.sv
// Purpose: Port-level checks for the loop and gain configuration block
// Assumes: One clock, asynchronous active-low reset
// Notes:   Bound to every instance of the block
`timescale 1ns/1ns
`default_nettype none
`include "bsa_defs.svh"
module bsa_checker (
    input wire logic                   ref_clk, reset_n, reg_wr, reg_rd,
    input wire logic [`BSA_ADDR_W-1:0] reg_addr,
    input wire logic [7:0]             reg_wdata, reg_rdata,
    input wire logic                   sync_detected, carrier_sense, loop_gate_on_carrier,
    input wire logic [3:0]             integral_gain_halves,
    input wire logic [2:0]             proportional_gain_mult, rate_offset_limit,
    input wire logic [2:0]             front_amp_cap_code,
    input wire logic [1:0]             digital_amp_barred_steps,
    input wire logic [5:0]             filter_target_db,
    input wire logic                   loops_frozen
);
    logic [5:0] db [8] = '{6'h18, 6'h1b, 6'h1e, 6'h21, 6'h24, 6'h26, 6'h28, 6'h2a};
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    reset_dflt_a: assert property ($rose(reset_n) |-> integral_gain_halves == 4'h4 &&
        proportional_gain_mult == 3'h3 && filter_target_db == 6'h21) else $error("bad defaults");
    int_gain_a: assert property (reg_wr && reg_addr == `BSA_BIT_SYNC_ADDR |-> ##2
        integral_gain_halves == (($past(sync_detected) && $past(reg_wdata[3], 2)) ? 4'h1 :
        {({1'b0, $past(reg_wdata[7:6], 2)} + 3'h1), 1'b0})) else $error("integral gain");
    prop_gain_a: assert property (reg_wr && reg_addr == `BSA_BIT_SYNC_ADDR |-> ##2
        proportional_gain_mult == (($past(sync_detected) && $past(reg_wdata[2], 2)) ? 3'h1 :
        {1'b0, $past(reg_wdata[5:4], 2)} + 3'h1)) else $error("proportional gain");
    rate_limit_a: assert property (reg_wr && reg_addr == `BSA_BIT_SYNC_ADDR |-> ##2
        rate_offset_limit == (($past(reg_wdata[1:0], 2) == 2'h3) ? 3'h4 :
        {1'b0, $past(reg_wdata[1:0], 2)})) else $error("rate limit");
    gain_fields_a: assert property (reg_wr && reg_addr == `BSA_GAIN_LIMITS_ADDR |-> ##2
        {digital_amp_barred_steps, front_amp_cap_code} == $past(reg_wdata[7:3], 2) &&
        filter_target_db == db[$past(reg_wdata[2:0], 2)]) else $error("gain fields");
    loop_freeze_a: assert property ($past(reset_n) |->
        loops_frozen == $past(loop_gate_on_carrier && !carrier_sense)) else $error("freeze");
    read_back_a: assert property (reg_wr ##1 reg_rd && $stable(reg_addr) && (reg_addr ==
        `BSA_BIT_SYNC_ADDR || reg_addr == `BSA_GAIN_LIMITS_ADDR) |=> reg_rdata == $past(reg_wdata, 2))
        else $error("readback");
    unmapped_rd_a: assert property (reg_rd && reg_addr != `BSA_BIT_SYNC_ADDR &&
        reg_addr != `BSA_GAIN_LIMITS_ADDR |=> reg_rdata == 8'h00) else $error("unmapped read");
    cover property (reg_rd && reg_addr == `BSA_GAIN_LIMITS_ADDR);
    cover property (reg_wr && sync_detected);
    cover property (loops_frozen);
endmodule
bind bsa_config_regs bsa_checker chk (.*);
`default_nettype wire

// ### verif/tb_bsa_config_regs.sv
// Purpose: Self-checking bench for the loop and gain configuration block
// Assumes: Inputs driven at the falling edge
// Notes:   Rows hold write data, sync level and expected loop outputs
`timescale 1ns/1ns
`default_nettype none
`include "bsa_defs.svh"
`define BSA_CHK(g, e) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
    $display("BAD %0t got %h want %h", $time, g, e); end end
module tb_bsa_config_regs;
    logic       ref_clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, sync_detected = 0;
    logic       carrier_sense = 0, loop_gate_on_carrier = 0, loops_frozen;
    logic [5:0] reg_addr = 6'h1a, filter_target_db;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    logic [3:0] integral_gain_halves;
    logic [2:0] proportional_gain_mult, rate_offset_limit, front_amp_cap_code;
    logic [1:0] digital_amp_barred_steps;
    int         bad_count = 0, comparisons = 0;
    logic [5:0] db [8] = '{6'h18, 6'h1b, 6'h1e, 6'h21, 6'h24, 6'h26, 6'h28, 6'h2a};
    logic [18:0] rows [5] = '{{8'h00, 1'b0, 4'h2, 3'h1, 3'h0}, {8'h5d, 1'b1, 4'h1, 3'h1, 3'h1},
        {8'ha2, 1'b1, 4'h6, 3'h3, 3'h2}, {8'hff, 1'b0, 4'h8, 3'h4, 3'h4},
        {8'hc4, 1'b1, 4'h8, 3'h1, 3'h0}};
    bsa_config_regs dut (.*);
    initial forever #20 ref_clk = ~ref_clk;
    task automatic give_verdict;
        $display("bad_count %0d comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic step(input logic [5:0] a, input logic [7:0] d, input logic w, input logic r);
        reg_addr = a; reg_wdata = d; reg_wr = w; reg_rd = r;
        @(negedge ref_clk);
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        step(a, 8'h00, 1'b0, 1'b1);
        reg_rd = 1'b0;
        `BSA_CHK(reg_rdata, e)
    endtask
    task automatic dflt;
        `BSA_CHK({integral_gain_halves, proportional_gain_mult, rate_offset_limit, digital_amp_barred_steps, front_amp_cap_code, filter_target_db}, {4'h4, 3'h3, 3'h0, 2'h0, 3'h0, 6'h21})
    endtask
    initial begin
        repeat (12) @(negedge ref_clk);
        dflt();
        reset_n = 1;
        rd(6'h1a, 8'h6c);
        rd(6'h1b, 8'h03);
        foreach (rows[i]) begin
            sync_detected = rows[i][10];
            step(6'h1a, rows[i][18:11], 1'b1, 1'b0);
            rd(6'h1a, rows[i][18:11]);
            `BSA_CHK({integral_gain_halves, proportional_gain_mult, rate_offset_limit}, rows[i][9:0])
        end
        for (int i = 0; i < 8; i++) begin
            step(6'h1b, {i[1:0], ~i[2:0], i[2:0]}, 1'b1, 1'b0);
            rd(6'h1b, {i[1:0], ~i[2:0], i[2:0]});
            `BSA_CHK({digital_amp_barred_steps, front_amp_cap_code, filter_target_db}, {i[1:0], ~i[2:0], db[i]})
        end
        step(6'h1c, 8'hff, 1'b1, 1'b0);
        rd(6'h1c, 8'h00);
        step(6'h1b, 8'h5a, 1'b1, 1'b1);
        `BSA_CHK(reg_rdata, 8'hc7)
        rd(6'h1b, 8'h5a);
        loop_gate_on_carrier = 1;
        step(6'h1b, 8'h00, 1'b0, 1'b0);
        `BSA_CHK(loops_frozen, 1'b1)
        carrier_sense = 1;
        step(6'h1b, 8'h00, 1'b0, 1'b0);
        `BSA_CHK(loops_frozen, 1'b0)
        reset_n = 0;
        #1 dflt();
        @(negedge ref_clk) reset_n = 1;
        rd(6'h1a, 8'h6c);
        give_verdict();
    end
    initial begin
        repeat (5000) @(posedge ref_clk);
        bad_count++;
        give_verdict();
    end
endmodule
`default_nettype wire
